// ==== core/lic_top.sv ====
// Contract
// - one rate bit sets every blinking indicator to 200 ms on/off when clear and 83 ms on/off when set.
// - bits 14, 9 and 4 make indicators 2, 1 and 0 blink instead of holding a steady level.
// - bits 13, 8 and 3 make indicators 2, 1 and 0 active high when set and active low when clear.
// - bits 12:10, 7:5 and 2:0 pick the displayed condition of indicators 2, 1 and 0.
// - after reset indicator 2 shows code 110, indicator 1 code 111, indicator 0 code 100 blinking, rest zero, so all three are active low.
// - code 000 shows a link up at 10 or 1000 Mb/s.
// - code 001 shows a link up at 100 or 1000 Mb/s.
// - code 010 shows a link up at any speed.
// - code 011 shows a link up with packets moving.
// - code 100 shows a link up with no traffic and goes off during traffic.
// - codes 101, 110 and 111 show a link up at exactly 10, 100 or 1000 Mb/s.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.svh"

module lic_top #(
   parameter int unsigned SLOW_HALF_CYCLES = `LIC_SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF_CYCLES = `LIC_FAST_HALF_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   output logic             err_o,
   // link state from the phy
   input  wire logic        link_up_i,
   input  wire logic [1:0]  link_speed_i,
   input  wire logic        activity_i,
   // indicator pins
   output logic             indicator_out_0,
   output logic             indicator_out_1,
   output logic             indicator_out_2
);

   localparam int unsigned CNT_MAX = (1 << `LIC_CNT_W);

   if (SLOW_HALF_CYCLES < 1 || SLOW_HALF_CYCLES > CNT_MAX ||
       FAST_HALF_CYCLES < 1 || FAST_HALF_CYCLES > CNT_MAX) begin : g_chk
      $error("lic_top: blink half period out of counter range");
   end

   localparam logic [`LIC_CNT_W-1:0] SLOW_LAST = `LIC_CNT_W'(SLOW_HALF_CYCLES - 1);
   localparam logic [`LIC_CNT_W-1:0] FAST_LAST = `LIC_CNT_W'(FAST_HALF_CYCLES - 1);

   lic_pkg::lic_top_st_t st_r;
   lic_pkg::lic_top_st_t st_nxt;

   logic [2:0] ind;
   logic [2:0] src;

   // indicator logic, one channel per indicator, all sharing the one blink phase
   for (genvar k = 0; k < 3; k++) begin : g_ch
      lic_channel u_ch (
         .clk_i           (clk_i),
         .rst_i           (rst_i),
         .link_up_i       (link_up_i),
         .speed_i         (link_speed_i),
         .activity_i      (activity_i),
         .phase_i         (st_r.phase),
         .mode_i          (st_r.cfg[k*`LIC_CH_STRIDE + `LIC_MODE_LSB +: `LIC_MODE_W]),
         .blink_en_i      (st_r.cfg[k*`LIC_CH_STRIDE + `LIC_BLINK_OFS]),
         .polarity_high_i (st_r.cfg[k*`LIC_CH_STRIDE + `LIC_POL_OFS]),
         .src_o           (src[k]),
         .ind_o           (ind[k])
      );
   end

   always_comb begin
      logic                  req;
      logic                  hit_cfg;
      logic                  hit_stat;
      logic                  rate;
      logic [`LIC_CNT_W-1:0] last;
      logic [31:0]           status;
      req      = cyc_i & stb_i & ~st_r.ack & ~st_r.err;
      hit_cfg  = (adr_i[7:2] == `LIC_CFG_IDX) && (adr_i[1:0] == 2'h0);
      hit_stat = (adr_i[7:2] == `LIC_STAT_IDX) && (adr_i[1:0] == 2'h0);
      rate     = st_r.cfg[`LIC_RATE_BIT];
      last     = rate ? FAST_LAST : SLOW_LAST;
      status   = 32'h0;
      status[`LIC_ST_OUT_LSB +: 3]  = ind;
      status[`LIC_ST_SRC_LSB +: 3]  = src;
      status[`LIC_ST_PHASE_BIT]     = st_r.phase;
      status[`LIC_ST_ACT_BIT]       = activity_i;
      status[`LIC_ST_SPD_LSB +: 2]  = link_speed_i;
      status[`LIC_ST_LINK_BIT]      = link_up_i;

      st_nxt      = st_r;
      st_nxt.ack  = 1'b0;
      st_nxt.err  = 1'b0;
      st_nxt.rate = rate;

      // free-running half-period counter, restarted cleanly on a rate change
      if (rate != st_r.rate) begin
         st_nxt.cnt   = '0;
         st_nxt.phase = 1'b1;
      end else if (st_r.cnt >= last) begin
         st_nxt.cnt   = '0;
         st_nxt.phase = ~st_r.phase;
      end else begin
         st_nxt.cnt   = st_r.cnt + `LIC_CNT_W'(1);
      end

      // register access, one answer per request
      if (req) begin
         if (hit_cfg) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = {16'h0, st_r.cfg};
            if (we_i) begin
               if (sel_i[0]) begin
                  st_nxt.cfg[7:0] = dat_i[7:0];
               end
               if (sel_i[1]) begin
                  st_nxt.cfg[15:8] = dat_i[15:8];
               end
            end
         end else if (hit_stat) begin
            st_nxt.ack = 1'b1;
            st_nxt.dat = status;
         end else begin
            st_nxt.err = 1'b1;
            st_nxt.dat = 32'h0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.cfg   <= `LIC_CFG_RST;
         st_r.cnt   <= '0;
         st_r.phase <= 1'b1;
         st_r.rate  <= 1'b0;
         st_r.ack   <= 1'b0;
         st_r.err   <= 1'b0;
         st_r.dat   <= 32'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dat_o           = st_r.dat;
   assign ack_o           = st_r.ack;
   assign err_o           = st_r.err;
   assign indicator_out_0 = ind[0];
   assign indicator_out_1 = ind[1];
   assign indicator_out_2 = ind[2];

endmodule

`default_nettype wire

// ==== core/lic_map.svh ====
`ifndef LIC_MAP_SVH
`define LIC_MAP_SVH

// clock and blink timing
`define LIC_CLK_HZ        50000000
`define LIC_SLOW_HALF_MS  200
`define LIC_FAST_HALF_MS  83
`define LIC_SLOW_HALF_CYC (`LIC_SLOW_HALF_MS * (`LIC_CLK_HZ / 1000))
`define LIC_FAST_HALF_CYC (`LIC_FAST_HALF_MS * (`LIC_CLK_HZ / 1000))
`define LIC_CNT_W         24

// register indices, byte address is four times the index
`define LIC_CFG_IDX       6'h1e
`define LIC_STAT_IDX      6'h1f

// configuration register layout
`define LIC_CFG_RST       16'h18f4
`define LIC_RATE_BIT      15
`define LIC_CH_STRIDE     5
`define LIC_MODE_LSB      0
`define LIC_MODE_W        3
`define LIC_POL_OFS       3
`define LIC_BLINK_OFS     4

// status register layout
`define LIC_ST_OUT_LSB    0
`define LIC_ST_SRC_LSB    3
`define LIC_ST_PHASE_BIT  6
`define LIC_ST_ACT_BIT    7
`define LIC_ST_SPD_LSB    8
`define LIC_ST_LINK_BIT   10

// indicator output level while in reset
`define LIC_OUT_RST       1'b1

`endif

// ==== core/lic_pkg.sv ====
`include "lic_map.svh"

package lic_pkg;

   typedef enum logic [2:0] {
      LIC_MODE_L10_1000  = 3'h0,
      LIC_MODE_L100_1000 = 3'h1,
      LIC_MODE_LINK      = 3'h2,
      LIC_MODE_ACT       = 3'h3,
      LIC_MODE_LINK_IDLE = 3'h4,
      LIC_MODE_L10       = 3'h5,
      LIC_MODE_L100      = 3'h6,
      LIC_MODE_L1000     = 3'h7
   } lic_mode_t;

   typedef enum logic [1:0] {
      LIC_SPD_10   = 2'h0,
      LIC_SPD_100  = 2'h1,
      LIC_SPD_1000 = 2'h2,
      LIC_SPD_RSVD = 2'h3
   } lic_speed_t;

   typedef struct packed {
      logic [15:0]            cfg;
      logic [`LIC_CNT_W-1:0]  cnt;
      logic                   phase;
      logic                   rate;
      logic                   ack;
      logic                   err;
      logic [31:0]            dat;
   } lic_top_st_t;

   typedef struct packed {
      logic src;
      logic out;
   } lic_ch_st_t;

endpackage

// ==== core/lic_channel.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.svh"

module lic_channel (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       link_up_i,
   input  wire logic [1:0] speed_i,
   input  wire logic       activity_i,
   input  wire logic       phase_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       blink_en_i,
   input  wire logic       polarity_high_i,
   output logic            src_o,
   output logic            ind_o
);

   lic_pkg::lic_ch_st_t st_r;
   lic_pkg::lic_ch_st_t st_nxt;

   always_comb begin
      logic is10;
      logic is100;
      logic is1000;
      logic src;
      logic lit;
      is10   = link_up_i & (speed_i == lic_pkg::LIC_SPD_10);
      is100  = link_up_i & (speed_i == lic_pkg::LIC_SPD_100);
      is1000 = link_up_i & (speed_i == lic_pkg::LIC_SPD_1000);
      src    = 1'b0;
      unique case (lic_pkg::lic_mode_t'(mode_i))
         lic_pkg::LIC_MODE_L10_1000:  src = is10 | is1000;
         lic_pkg::LIC_MODE_L100_1000: src = is100 | is1000;
         lic_pkg::LIC_MODE_LINK:      src = link_up_i;
         lic_pkg::LIC_MODE_ACT:       src = link_up_i & activity_i;
         lic_pkg::LIC_MODE_LINK_IDLE: src = link_up_i & ~activity_i;
         lic_pkg::LIC_MODE_L10:       src = is10;
         lic_pkg::LIC_MODE_L100:      src = is100;
         lic_pkg::LIC_MODE_L1000:     src = is1000;
      endcase
      lit        = src & (~blink_en_i | phase_i);
      st_nxt     = st_r;
      st_nxt.src = src;
      st_nxt.out = polarity_high_i ? lit : ~lit;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.src <= 1'b0;
         st_r.out <= `LIC_OUT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign src_o = st_r.src;
   assign ind_o = st_r.out;

endmodule

`default_nettype wire

// ==== verification/lic_top_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.svh"
module lic_top_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        err_o,
   input wire logic        link_up_i,
   input wire logic        indicator_out_0,
   input wire logic        indicator_out_1,
   input wire logic        indicator_out_2
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic        tk;
   logic [15:0] cfg_s;
   logic [2:0]  pins;
   assign tk = cyc_i && stb_i && !ack_o && !err_o;
   assign pins = {indicator_out_2, indicator_out_1, indicator_out_0};
   // shadow of the config register, byte lanes per sel
   always_ff @(posedge clk_i) begin
      if (rst_i) cfg_s <= `LIC_CFG_RST;
      else if (tk && we_i && adr_i == 8'h78)
         cfg_s <= {sel_i[1] ? dat_i[15:8] : cfg_s[15:8], sel_i[0] ? dat_i[7:0] : cfg_s[7:0]};
   end
   sequence req_s; tk; endsequence
   sequence mapped_s; tk && (adr_i == 8'h78 || adr_i == 8'h7c); endsequence
   sequence unmapped_s; tk && adr_i != 8'h78 && adr_i != 8'h7c; endsequence
   sequence cfg_rd_s; tk && !we_i && adr_i == 8'h78; endsequence
   wb_answer_a: assert property (req_s |=> ack_o ^ err_o) else $error("no single answer");
   ack_ok_a: assert property (mapped_s |=> ack_o) else $error("no ack");
   err_bad_a: assert property (unmapped_s |=> err_o && dat_o == 32'h0) else $error("no err");
   ack_pulse_a: assert property (ack_o || err_o |=> !ack_o && !err_o) else $error("long answer");
   dat_hold_a: assert property (!ack_o && !err_o |-> $stable(dat_o)) else $error("data moved");
   upper_zero_a: assert property (ack_o |-> dat_o[31:16] == 16'h0) else $error("upper bits");
   cfg_read_a: assert property (cfg_rd_s |=> dat_o[15:0] == $past(cfg_s)) else $error("cfg value");
   out_reset_a: assert property (disable iff (1'b0) rst_i |=> pins == 3'h7) else $error("reset pins");
   unlit_level_a: assert property ($past(!link_up_i) && $stable(cfg_s) |->
      pins == ~{cfg_s[13], cfg_s[8], cfg_s[3]}) else $error("unlit level");
endmodule
bind lic_top lic_top_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
   .err_o, .link_up_i, .indicator_out_0, .indicator_out_1, .indicator_out_2);
`default_nettype wire

// ==== verification/lic_lamp_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module lic_lamp_model (
   input wire logic [2:0] pin_i,
   input wire logic [2:0] polarity_high_i,
   output logic [2:0]     lit_o
);
   assign lit_o = ~(pin_i ^ polarity_high_i);
endmodule
`default_nettype wire

// ==== verification/lic_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module lic_top_tb_top;
   logic        clk_i, rst_i, cyc, stb, we, link, act, e, ack_o, err_o;
   logic [1:0]  spd;
   logic [2:0]  pin, lit, pol;
   logic [3:0]  sel;
   logic [7:0]  adr;
   logic [31:0] wdat, dat_o, q;
   int          fail_count = 0, checked = 0, n, k, m, p, l, s, a;
   lic_top #(.SLOW_HALF_CYCLES(20), .FAST_HALF_CYCLES(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
      .err_o(err_o), .link_up_i(link), .link_speed_i(spd), .activity_i(act), .indicator_out_0(pin[0]),
      .indicator_out_1(pin[1]), .indicator_out_2(pin[2]));
   lic_lamp_model lamps (.pin_i(pin), .polarity_high_i(pol), .lit_o(lit));
   function automatic logic src(input logic [2:0] md, input logic lu, input logic [1:0] sp, input logic ac);
      case (md)
         3'h0: return lu && (sp == 2'h0 || sp == 2'h2);
         3'h1: return lu && (sp == 2'h1 || sp == 2'h2);
         3'h2: return lu;
         3'h3: return lu && ac;
         3'h4: return lu && !ac;
         default: return lu && sp == 2'(md - 3'h5);
      endcase
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task end_of_test;
      if (fail_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] se);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d; sel <= se;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      e = err_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   // skips two pin changes, then counts cycles of one blink half
   task half;
      logic v;
      repeat (2) begin
         v = pin[0];
         while (pin[0] === v) @(posedge clk_i);
      end
      v = pin[0];
      for (n = 0; pin[0] === v; n++) @(posedge clk_i);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      #800000;
      fail_count++;
      end_of_test;
   end
   initial begin
      rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; wdat = 0; link = 0; spd = 0; act = 0; pol = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(0, 8'h78, 0, 4'h3); chk(q, 32'h18f4);
      xfer(0, 8'h42, 0, 4'h3); chk(32'(e), 1);
      xfer(1, 8'h78, 32'habcd, 4'h1); xfer(0, 8'h78, 0, 4'h3); chk(q, 32'h18cd);
      for (k = 0; k < 3; k++) for (m = 0; m < 8; m++) for (p = 0; p < 2; p++) begin
         xfer(1, 8'h78, 32'(((p << 3) | m) << (5 * k)), 4'h3);
         pol <= 3'(p << k);
         for (l = 0; l < 2; l++) for (s = 0; s < 4; s++) for (a = 0; a < 2; a++) begin
            link <= 1'(l); spd <= 2'(s); act <= 1'(a);
            repeat (3) @(posedge clk_i);
            chk(32'(lit[k]), 32'(src(3'(m), 1'(l), 2'(s), 1'(a))));
         end
      end
      spd <= 2'h2; pol <= 3'h0;
      xfer(1, 8'h7c, 32'hffff, 4'h3); chk(32'(e), 0);
      xfer(0, 8'h7c, 0, 4'h3); chk(q & 32'hffff_ffbf, 32'h06bc);
      act <= 1'b0;
      xfer(1, 8'h78, 32'h0014, 4'h3);
      half; chk(n, 20);
      xfer(1, 8'h78, 32'h8014, 4'h3);
      half; chk(n, 8);
      act <= 1'b1;
      repeat (3) @(posedge clk_i);
      repeat (20) begin
         @(posedge clk_i); chk(32'(pin[0]), 1);
      end
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      xfer(0, 8'h78, 0, 4'h3); chk(q, 32'h18f4);
      end_of_test;
   end
endmodule
`default_nettype wire
